//--- core/wdt_top.sv
/*
 Watchdog timer with AXI4-Lite registers, prescaler, postscaler, window
 mode and sleep/idle wake-up. Assumes core events are one-cycle pulses
 synchronous to aclk and that reset_request is fed back as aresetn.
*/
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
module wdt_top #(
   parameter int unsigned CLK_DIV = wdt_pkg::LOW_POWER_RC_OSC_DIV
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [3:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [3:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire wdt_pkg::wdt_core_ev_t core_ev,
   output logic                     low_power_rc_osc,
   output logic                     reset_request,
   output logic                     wake_request,
   output wdt_pkg::wdt_mode_t       power_mode
);
   localparam int unsigned CW = wdt_pkg::CNT_W;
   localparam int CLR_BOUND = 320;

   typedef struct packed {
      wdt_pkg::wdt_cfg_t  cfg;
      logic               sw_en;
      logic               flag;
      logic               slp;
      logic               idl;
      wdt_pkg::wdt_mode_t mode;
      logic [CW-1:0]      cnt;
      logic               pend_clr;
      logic               rst_req;
      logic               wake;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [1:0]         rresp;
      logic [31:0]        rdata;
   } wdt_st_t;

   wdt_st_t       s_q;
   wdt_st_t       s_d;
   logic          en;
   logic          tick;
   logic [CW-1:0] period;
   logic [CW-1:0] win_open;
   logic          early;
   logic          wr_go;
   logic          rd_go;
   logic          clr_ok;
   logic          expire;

   // ==========================================================
   // Enable and rate
   assign en = s_q.cfg.hw_watchdog_enable | s_q.sw_en;
   assign low_power_rc_osc = en;

   wdt_rate_div #(
      .DIV (CLK_DIV)
   ) u_rc_rate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (en),
      .tick    (tick)
   );

   // ==========================================================
   // Period and window
   always_comb begin
      period = s_q.cfg.prescale_select ? CW'(wdt_pkg::PRE_LONG)
                                       : CW'(wdt_pkg::PRE_SHORT);
      period = period << s_q.cfg.postscale_select;
      win_open = period - (period >> 2);
   end

   assign clr_ok = core_ev.clear_watchdog_instr &&
                   s_q.mode == wdt_pkg::WDT_RUN;
   assign early = clr_ok && en && !s_q.cfg.window_disable &&
                  !s_q.pend_clr && s_q.cnt < win_open;
   assign expire = tick && en && !s_q.pend_clr &&
                   s_q.cnt == period - CW'(1);

   // ==========================================================
   // Bus handshakes
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
   assign rd_go = s_axi_arvalid && !s_q.rvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   // ==========================================================
   // Next state
   always_comb begin
      s_d         = s_q;
      s_d.rst_req = 1'b0;
      s_d.wake    = 1'b0;
      if (!en) begin
         s_d.cnt      = '0;
         s_d.pend_clr = 1'b0;
      end else if (tick) begin
         if (s_q.pend_clr) begin
            s_d.cnt      = '0;
            s_d.pend_clr = 1'b0;
         end else if (expire) begin
            s_d.cnt = '0;
         end else begin
            s_d.cnt = s_q.cnt + CW'(1);
         end
      end
      // Events are raised after the tick so a tick never swallows one;
      // they wait for the next RC tick before touching counts
      if (en && (clr_ok || core_ev.clock_switch_done)) begin
         s_d.pend_clr = 1'b1;
      end
      // Register writes; hardware sets below win over software clears
      if (wr_go) begin
         s_d.bvalid = 1'b1;
         s_d.bresp  = wdt_pkg::RESP_OKAY;
         if (s_axi_awaddr == wdt_pkg::OFS_CONFIG) begin
            if (s_axi_wstrb[0]) begin
               s_d.cfg = wdt_pkg::wdt_cfg_t'(s_axi_wdata[7:0]);
            end
         end else if (s_axi_awaddr == wdt_pkg::OFS_RESETCTL) begin
            if (s_axi_wstrb[0]) begin
               s_d.sw_en = s_axi_wdata[wdt_pkg::RC_SWEN_BIT];
               s_d.flag  = s_q.flag &
                           s_axi_wdata[wdt_pkg::RC_FLAG_BIT];
               s_d.slp   = s_d.slp & s_axi_wdata[wdt_pkg::RC_SLP_BIT];
               s_d.idl   = s_d.idl & s_axi_wdata[wdt_pkg::RC_IDL_BIT];
            end
         end else if (s_axi_awaddr != wdt_pkg::OFS_COUNT) begin
            s_d.bresp = wdt_pkg::RESP_DECERR;
         end
      end else if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      // Mode changes after the write, so a status set beats a clear
      if (core_ev.power_save_instr && s_q.mode == wdt_pkg::WDT_RUN) begin
         s_d.pend_clr = en;
         if (core_ev.power_save_idle) begin
            s_d.mode = wdt_pkg::WDT_IDLE;
            s_d.idl  = 1'b1;
         end else begin
            s_d.mode = wdt_pkg::WDT_SLEEP;
            s_d.slp  = 1'b1;
         end
      end
      if (core_ev.wake_event && s_q.mode != wdt_pkg::WDT_RUN) begin
         s_d.mode     = wdt_pkg::WDT_RUN;
         s_d.pend_clr = en;
      end
      // Timeout and early clear outcomes
      if (expire && s_q.mode != wdt_pkg::WDT_RUN) begin
         s_d.wake     = 1'b1;
         s_d.flag     = 1'b1;
         s_d.mode     = wdt_pkg::WDT_RUN;
         s_d.pend_clr = 1'b1;
      end else if (expire || early) begin
         s_d.rst_req = 1'b1;
         s_d.flag    = 1'b1;
      end
      // Register reads
      if (rd_go) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = wdt_pkg::RESP_OKAY;
         s_d.rdata  = '0;
         unique case (s_axi_araddr)
            wdt_pkg::OFS_CONFIG: begin
               s_d.rdata[7:0] = s_q.cfg;
            end
            wdt_pkg::OFS_RESETCTL: begin
               s_d.rdata[wdt_pkg::RC_SWEN_BIT] = s_q.sw_en;
               s_d.rdata[wdt_pkg::RC_FLAG_BIT] = s_q.flag;
               s_d.rdata[wdt_pkg::RC_SLP_BIT]  = s_q.slp;
               s_d.rdata[wdt_pkg::RC_IDL_BIT]  = s_q.idl;
            end
            wdt_pkg::OFS_COUNT: begin
               s_d.rdata[CW-1:0] = s_q.cnt;
            end
            default: begin
               s_d.rresp = wdt_pkg::RESP_DECERR;
            end
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q      <= '0;
         s_q.cfg  <= wdt_pkg::CFG_RESET;
         s_q.mode <= wdt_pkg::WDT_RUN;
         // Flag survives the watchdog's own reset so software can see it
         s_q.flag <= s_q.rst_req;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rdata   = s_q.rdata;
   assign reset_request = s_q.rst_req;
   assign wake_request  = s_q.wake;
   assign power_mode    = s_q.mode;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_run_expire;
      expire && s_q.mode == wdt_pkg::WDT_RUN;
   endsequence

   sequence s_save_expire;
      expire && s_q.mode != wdt_pkg::WDT_RUN;
   endsequence

   sequence s_ps_entry;
      core_ev.power_save_instr && s_q.mode == wdt_pkg::WDT_RUN && en;
   endsequence

   a_hw_forces_osc: assert property (
      s_q.cfg.hw_watchdog_enable |-> low_power_rc_osc && en)
      else $error("Hardware enable did not keep oscillator on");

   a_disabled_idle: assert property (
      !s_q.cfg.hw_watchdog_enable && !s_q.sw_en |=> s_q.cnt == '0)
      else $error("Disabled watchdog kept counting");

   // Self-reset follows these at once: only an outside reset disables them
   a_run_timeout: assert property (
      disable iff (!aresetn && !reset_request)
      s_run_expire |=> reset_request && s_q.flag && !wake_request)
      else $error("Run timeout did not request reset");

   a_sleep_wake: assert property (
      s_save_expire |=> wake_request && !reset_request &&
                        power_mode == wdt_pkg::WDT_RUN)
      else $error("Power-save timeout did not wake");

   a_early_clear: assert property (
      disable iff (!aresetn && !reset_request)
      early |=> reset_request)
      else $error("Early clear in window mode did not reset");

   a_clear_lands: assert property (
      clr_ok && en && !early |-> ##[1:CLR_BOUND] s_q.cnt == '0)
      else $error("Clear never zeroed the count");

   a_ps_clears: assert property (
      s_ps_entry |=> power_mode != wdt_pkg::WDT_RUN ##0
                     s_q.pend_clr ##[1:CLR_BOUND] s_q.cnt == '0)
      else $error("Power-save entry did not clear counts");

   a_flag_sticky: assert property (
      s_q.flag && !(wr_go && s_axi_awaddr == wdt_pkg::OFS_RESETCTL)
      |=> s_q.flag)
      else $error("Timeout flag dropped without a write");

   a_count_bound: assert property (
      en |-> s_q.cnt < period || $past(s_q.cfg) != s_q.cfg)
      else $error("Count exceeded selected period");

   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early");

   a_late_clear: assert property (
      clr_ok && en && !s_q.cfg.window_disable && !expire && !s_q.pend_clr &&
      s_q.cnt >= win_open |=> !reset_request)
      else $error("Clear inside the window caused a reset");

   a_nowin_clear: assert property (
      clr_ok && s_q.cfg.window_disable && !expire |=> !reset_request)
      else $error("Clear in non-window mode caused a reset");

   a_tick_only: assert property (
      en && !tick |=> $stable(s_q.cnt))
      else $error("Count moved without an RC tick");

   a_swen_reset: assert property (
      $rose(aresetn) |-> !s_q.sw_en && s_q.cnt == '0)
      else $error("Reset left enable or count set");

   a_ps_status: assert property (
      core_ev.power_save_instr && s_q.mode == wdt_pkg::WDT_RUN
      |=> s_q.slp || s_q.idl)
      else $error("Power-save entry left no status bit");

   a_wake_flag: assert property (
      s_save_expire |=> s_q.flag)
      else $error("Power-save timeout left the flag clear");

   a_wake_pulse: assert property (
      wake_request |=> !wake_request)
      else $error("Wake request held longer than a cycle");

   a_osc_follows: assert property (
      !s_q.cfg.hw_watchdog_enable && !s_q.sw_en |-> !low_power_rc_osc)
      else $error("Oscillator left on while disabled");
endmodule

//--- core/wdt_pkg.sv
/*
 Constants and carriers for the watchdog timer: register offsets, field
 positions, reset values, power modes and clock-rate counts.
 Assumes a 10 MHz system clock and a nominal 32 kHz low-power RC rate.
*/
package wdt_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned SYS_CLK_HZ  = 10_000_000;
   localparam int unsigned LOW_POWER_RC_OSC_HZ     = 32_000;
   localparam int unsigned LOW_POWER_RC_OSC_DIV    = SYS_CLK_HZ / LOW_POWER_RC_OSC_HZ;
   localparam int unsigned PRE_SHORT   = 32;
   localparam int unsigned PRE_LONG    = 128;
   localparam int unsigned CNT_W       = 23;
   // ==========================================================
   // Register map
   localparam logic [3:0] OFS_CONFIG   = 4'h0;
   localparam logic [3:0] OFS_RESETCTL = 4'h4;
   localparam logic [3:0] OFS_COUNT    = 4'h8;
   // Config word fields
   localparam int unsigned CFG_POST_LSB = 0;
   localparam int unsigned CFG_PRE_BIT  = 4;
   localparam int unsigned CFG_WDIS_BIT = 6;
   localparam int unsigned CFG_HWEN_BIT = 7;
   localparam logic [7:0]  CFG_RESET    = 8'hc0;
   // Reset control fields
   localparam int unsigned RC_SWEN_BIT  = 5;
   localparam int unsigned RC_FLAG_BIT  = 4;
   localparam int unsigned RC_SLP_BIT   = 3;
   localparam int unsigned RC_IDL_BIT   = 2;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_DECERR  = 2'h3;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      WDT_RUN   = 2'h0,
      WDT_SLEEP = 2'h1,
      WDT_IDLE  = 2'h3
   } wdt_mode_t;

   typedef struct packed {
      logic       hw_watchdog_enable;
      logic       window_disable;
      logic       unused5;
      logic       prescale_select;
      logic [3:0] postscale_select;
   } wdt_cfg_t;

   typedef struct packed {
      logic clear_watchdog_instr;
      logic power_save_instr;
      logic power_save_idle;
      logic clock_switch_done;
      logic wake_event;
   } wdt_core_ev_t;
endpackage

//--- core/wdt_rate_div.sv
/*
 Rate divider: emits a one-cycle enable pulse every DIV clocks while run
 is high; restarts from zero whenever run is low.
 Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module wdt_rate_div #(
   parameter int unsigned DIV = 312
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   output logic      tick
);
   localparam int unsigned W = $clog2(DIV);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } wdt_div_st_t;

   wdt_div_st_t s_q;
   wdt_div_st_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!run) begin
         s_d.cnt = '0;
      end else if (s_q.cnt == LAST) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + W'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;
endmodule

//--- verification/wdt_core_model.sv
/*
 Processor core model: issues clear, power-save, clock-switch-done and
 wake events as one-cycle pulses on the watchdog's core event port.
 Assumes the bench calls fire() from its main sequence on aclk.
*/
`timescale 1ns/1ns
module wdt_core_model (
   input  wire logic             aclk,
   output wdt_pkg::wdt_core_ev_t core_ev
);
   initial core_ev = '0;
   // ==========
   // Event pulse
   task automatic fire(input int idx, input logic idle);
      @(posedge aclk);
      core_ev <= 5'(1 << idx) | {2'h0, idle, 2'h0};
      @(posedge aclk);
      core_ev <= '0;
   endtask
endmodule

//--- verification/tb_wdt_top.sv
/*
 Testbench for the watchdog timer: AXI4-Lite master tasks and scenarios.
 Assumes wdt_pkg, wdt_top and wdt_core_model are compiled first.
*/
`timescale 1ns/1ns
module tb_wdt_top;
   localparam int D = 4;
   logic                  aclk = 1'b0;
   logic                  por_n = 1'b0;
   logic                  aresetn;
   logic [3:0]            awaddr = 4'h0;
   logic [3:0]            araddr = 4'h0;
   logic                  awvalid = 1'b0;
   logic                  wvalid = 1'b0;
   logic                  bready = 1'b0;
   logic                  arvalid = 1'b0;
   logic                  rready = 1'b0;
   logic [31:0]           wdata = 32'h0;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp;
   logic [31:0]           rdata, rd;
   wdt_pkg::wdt_core_ev_t core_ev;
   logic                  osc_on, rst_req, wake_req;
   wdt_pkg::wdt_mode_t    mode;
   int                    err_total = 0;
   int                    n_compared = 0;
   int                    n, p;
   logic [7:0]            cf [4] = '{8'h40, 8'h50, 8'h42, 8'h41};
   int                    ev [3] = '{4, 1, 0};

   always #50 aclk = ~aclk;
   assign aresetn = por_n & ~rst_req;

   wdt_top #(.CLK_DIV(D)) u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_ev(core_ev),
      .low_power_rc_osc(osc_on), .reset_request(rst_req),
      .wake_request(wake_req), .power_mode(mode));

   wdt_core_model u_core (.aclk(aclk), .core_ev(core_ev));

   // ==========
   // Checks and bus tasks
   task automatic check(input string s, input logic [31:0] e,
                        input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic ok(input string s, input logic c);
      check(s, 32'h1, {31'h0, c});
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (!(awready === 1'b1 && wready === 1'b1) && t < 50);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do begin
         @(posedge aclk);
         t++;
      end while (bvalid !== 1'b1 && t < 50);
      bready <= 1'b0;
      check("write resp", {30'h0, wdt_pkg::RESP_OKAY}, {30'h0, bresp});
      if (t >= 50) err_total++;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [1:0] er);
      int t;
      t = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
      end while (arready !== 1'b1 && t < 50);
      arvalid <= 1'b0;
      do begin
         @(posedge aclk);
         t++;
      end while (rvalid !== 1'b1 && t < 50);
      rready <= 1'b0;
      rd = rdata;
      check("read resp", {30'h0, er}, {30'h0, rresp});
      if (t >= 50) err_total++;
   endtask

   task automatic wait_pulse(input logic wk, input int lim, output int c);
      c = 0;
      do begin
         @(posedge aclk);
         c++;
      end while ((wk ? wake_req : rst_req) !== 1'b1 && c < lim);
   endtask

   task automatic wait_count(input int th);
      int t;
      t = 0;
      do begin
         rdc(wdt_pkg::OFS_COUNT, wdt_pkg::RESP_OKAY);
         t++;
      end while (rd < th && t < 100);
      if (rd < th) check("count reach", th, rd);
   endtask

   task automatic stop();
      wr(wdt_pkg::OFS_CONFIG, 32'h40);
      wr(wdt_pkg::OFS_RESETCTL, 32'h0);
   endtask

   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========
   // Scenarios
   initial begin
      repeat (6) @(posedge aclk);
      por_n <= 1'b1;
      rdc(wdt_pkg::OFS_CONFIG, wdt_pkg::RESP_OKAY);
      check("config reset", 32'hc0, rd);
      ok("osc on", osc_on === 1'b1);
      rdc(wdt_pkg::OFS_RESETCTL, wdt_pkg::RESP_OKAY);
      check("sw enable reset", 32'h0, {31'h0, rd[5]});
      rdc(4'hc, wdt_pkg::RESP_DECERR);
      wait_pulse(1'b0, 40 * D, n);
      ok("run timeout", n >= 29 * D && n <= 33 * D + 2);
      rdc(wdt_pkg::OFS_COUNT, wdt_pkg::RESP_OKAY);
      ok("count after reset", rd < 3);
      rdc(wdt_pkg::OFS_RESETCTL, wdt_pkg::RESP_OKAY);
      check("timeout flag", 32'h10, rd);
      stop();
      ok("osc off", osc_on === 1'b0);
      repeat (10 * D) @(posedge aclk);
      rdc(wdt_pkg::OFS_COUNT, wdt_pkg::RESP_OKAY);
      check("count disabled", 32'h0, rd);
      wr(wdt_pkg::OFS_CONFIG, 32'hc0);
      wait_count(3);
      ok("hw enable overrides", rd >= 3 && osc_on === 1'b1);
      stop();
      for (int i = 0; i < 4; i++) begin
         p = (cf[i][4] ? 128 : 32) << cf[i][3:0];
         wr(wdt_pkg::OFS_CONFIG, {24'h0, cf[i]});
         wr(wdt_pkg::OFS_RESETCTL, 32'h20);
         u_core.fire(3, 1'(i % 2));
         @(posedge aclk);
         check("mode", (i % 2) ? 2'h3 : 2'h1, mode);
         wait_pulse(1'b1, p * D + 3 * D, n);
         ok("wake time", n >= (p - 1) * D - 1 && n <= p * D + 2);
         check("mode woken", {30'h0, wdt_pkg::WDT_RUN}, mode);
         rdc(wdt_pkg::OFS_RESETCTL, wdt_pkg::RESP_OKAY);
         check("status", (i % 2) ? 32'h34 : 32'h38, rd);
         wr(wdt_pkg::OFS_RESETCTL, 32'h0);
         rdc(wdt_pkg::OFS_RESETCTL, wdt_pkg::RESP_OKAY);
         check("status cleared", 32'h0, rd);
      end
      for (int i = 0; i < 3; i++) begin
         wr(wdt_pkg::OFS_RESETCTL, 32'h20);
         if (ev[i] == 0) u_core.fire(3, 1'b0);
         wait_count(12);
         u_core.fire(ev[i], 1'b0);
         repeat (D + 2) @(posedge aclk);
         rdc(wdt_pkg::OFS_COUNT, wdt_pkg::RESP_OKAY);
         ok("count cleared", rd < 3);
         stop();
      end
      wr(wdt_pkg::OFS_CONFIG, 32'h00);
      wr(wdt_pkg::OFS_RESETCTL, 32'h20);
      wait_count(25);
      u_core.fire(4, 1'b0);
      wait_pulse(1'b0, 3 * D, n);
      ok("late clear kept", n == 3 * D);
      wait_count(4);
      u_core.fire(4, 1'b0);
      wait_pulse(1'b0, 3 * D, n);
      ok("early clear reset", n < 3 * D);
      stop();
      print_verdict();
   end

   initial begin
      #2_000_000;
      err_total++;
      print_verdict();
   end
endmodule
